// File: ddc_defines.svh
// Purpose: Constants of the descriptor DMA stream.
// Assumes: 32-bit byte addresses, word-aligned elements.
// Notes: Included by the package, the engine and the checker.
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH
// ********************
// Widths and depths
// ********************
`define DDC_AW 32
`define DDC_DW 32
`define DDC_CW 16
`define DDC_FIFO_DEPTH 16
`define DDC_FIFO_AW 4
// ********************
// Descriptor layout
// ********************
`define DDC_WORD_BYTES 32'h0000_0004
`define DDC_NW_ARRAY 3'h1
`define DDC_NW_PING 3'h2
`define DDC_NW_LIST 3'h4
`define DDC_NW_LIST2D 3'h7
`define DDC_CFG_FLOW_LSB 0
`define DDC_CFG_FLOW_MSB 2
`endif

// File: ddc_pkg.sv
// Purpose: Types of the descriptor DMA stream.
// Assumes: ddc_defines.svh is on the include path.
// Notes: Flow and direction codes are port encodings.
`include "ddc_defines.svh"
package ddc_pkg;
  // ********************
  // Types
  // ********************
  typedef enum logic [2:0] {
    FL_STOP = 3'h0, FL_AUTO = 3'h1, FL_ARRAY = 3'h4,
    FL_PING = 3'h5, FL_LIST = 3'h6, FL_LIST2D = 3'h7
  } ddc_flow_type;
  typedef enum logic [1:0] {
    DIR_M2M = 2'h0, DIR_M2P = 2'h1, DIR_P2M = 2'h2
  } ddc_dir_type;
  typedef enum {ST_IDLE, ST_FETCH, ST_RUN} ddc_state_type;
  typedef enum {TAG_DESC, TAG_SRC, TAG_DST} ddc_tag_type;
endpackage : ddc_pkg

// File: ddc_fifo.sv
// Purpose: Flip-flop FIFO between source and destination channel.
// Assumes: One push and one pop per cycle at most.
// Notes: Flush empties it in one cycle.
module ddc_fifo #(
  parameter int W = 32,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [AW:0] count_o
);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign in_ready_o = (cnt_r < (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign count_o = cnt_r;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  // Storage has no reset; only pointers matter
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ddc_fifo

// File: ddc_dma.sv
// Purpose: One memory DMA stream: source and destination channel pair.
// Assumes: Memory slave answers one request at a time with ack.
// Notes: Counts of zero are not supported; setup is by ports.
// Overview of operation
// - Memory-peripheral, peripheral-memory, memory-memory moves
// - Stream uses source and destination channel
// - Any address reachable, no region limits
// - Transfer runs alone after setup
// - Setup presented on ports, then start launches
// - Autobuffer restores setup and restarts
// - Descriptor modes fetch parameters first
// - Chained descriptors load and continue automatically
// - Stop mode halts after one buffer
// - Strides may be negative, positive, zero
// - Circular buffer interrupts when full
// - Optional half or quarter buffer interrupts
// - Ping-pong ring: link and address
// - List: link, address, length, config
// - Array: sequential one-word base addresses
// - 2D list: link, address, both counts, source strides, config
`include "ddc_defines.svh"
module ddc_dma (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic clear_i,
  input wire ddc_pkg::ddc_flow_type flow_i,
  input wire ddc_pkg::ddc_dir_type dir_i,
  input wire logic [1:0] frac_i,
  input wire logic [`DDC_AW-1:0] desc_ptr_i,
  input wire logic [`DDC_AW-1:0] src_addr_i,
  input wire logic [`DDC_AW-1:0] dst_addr_i,
  input wire logic [`DDC_CW-1:0] xcnt_i,
  input wire logic [`DDC_CW-1:0] ycnt_i,
  input wire logic [`DDC_AW-1:0] src_xmod_i,
  input wire logic [`DDC_AW-1:0] src_ymod_i,
  input wire logic [`DDC_AW-1:0] dst_xmod_i,
  input wire logic [`DDC_AW-1:0] dst_ymod_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [`DDC_AW-1:0] mem_addr_o,
  output logic [`DDC_DW-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic [`DDC_DW-1:0] mem_rdata_i,
  input wire logic per_rx_valid_i,
  input wire logic [`DDC_DW-1:0] per_rx_data_i,
  output logic per_rx_ready_o,
  output logic per_tx_valid_o,
  output logic [`DDC_DW-1:0] per_tx_data_o,
  input wire logic per_tx_ready_i,
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic irq_o
);
  // ********************
  // Helpers
  // ********************
  // Next address: inner stride, or outer stride at row end
  function automatic logic [`DDC_AW-1:0] step_addr(
    input logic [`DDC_AW-1:0] a, input logic [`DDC_CW-1:0] xl,
    input logic [`DDC_AW-1:0] xm, input logic [`DDC_AW-1:0] ym);
    step_addr = a + ((xl == `DDC_CW'h1) ? ym : xm);
  endfunction : step_addr

  // Next {inner, outer} remaining counts
  function automatic logic [2*`DDC_CW-1:0] step_cnt(
    input logic [`DDC_CW-1:0] xl, input logic [`DDC_CW-1:0] yl,
    input logic [`DDC_CW-1:0] xc);
    if (xl == `DDC_CW'h1) step_cnt = {xc, yl - 1'b1};
    else step_cnt = {xl - 1'b1, yl};
  endfunction : step_cnt

  // Descriptor size by flow
  function automatic logic [2:0] desc_words(input ddc_pkg::ddc_flow_type f);
    unique case (f)
      ddc_pkg::FL_ARRAY: desc_words = `DDC_NW_ARRAY;
      ddc_pkg::FL_PING: desc_words = `DDC_NW_PING;
      ddc_pkg::FL_LIST: desc_words = `DDC_NW_LIST;
      default: desc_words = `DDC_NW_LIST2D;
    endcase
  endfunction : desc_words

  // ********************
  // State
  // ********************
  ddc_pkg::ddc_state_type st_r;
  ddc_pkg::ddc_flow_type flow_r;
  ddc_pkg::ddc_dir_type dir_r;
  ddc_pkg::ddc_tag_type tag_r;
  logic [1:0] frac_r;
  logic [`DDC_AW-1:0] dptr_r, next_r, sa_r, da_r, sa0_r, da0_r;
  logic [`DDC_AW-1:0] sxm_r, sym_r, dxm_r, dym_r;
  logic [`DDC_CW-1:0] xc_r, yc_r, sxl_r, syl_r, dxl_r, dyl_r;
  logic [2:0] widx_r;
  logic [`DDC_AW-1:0] fcnt_r;
  logic req_r, we_r, rxr_r, txv_r, done_r, err_r, irq_r;
  logic [`DDC_AW-1:0] addr_r;
  logic [`DDC_DW-1:0] wd_r, txd_r;

  logic run, want_desc, want_dst, want_src, go_desc, go_dst, go_src;
  logic ack_ok, ack_err, rx_acc, tx_load, src_step, dst_step, seq_end;
  logic fin_ok, fin_desc, in_ready, f_valid, f_push;
  logic [`DDC_DW-1:0] f_out, f_in;
  logic [`DDC_FIFO_AW:0] f_cnt;
  logic [`DDC_AW-1:0] frac_len;
  logic [`DDC_AW-1:0] dword;

  // ********************
  // Arbitration of the memory port
  // ********************
  // Descriptor fetch first, then writes so the FIFO drains before reads
  assign run = (st_r == ddc_pkg::ST_RUN);
  assign want_desc = (st_r == ddc_pkg::ST_FETCH);
  assign want_dst = run && dir_r != ddc_pkg::DIR_M2P && f_valid && dyl_r != '0;
  assign want_src = run && dir_r != ddc_pkg::DIR_P2M && in_ready && syl_r != '0;
  assign go_desc = !req_r && want_desc;
  assign go_dst = !req_r && !want_desc && want_dst;
  assign go_src = !req_r && !want_desc && !want_dst && want_src;
  assign ack_ok = req_r && mem_ack_i && !mem_err_i;
  assign ack_err = req_r && mem_ack_i && mem_err_i;
  assign dword = mem_rdata_i;

  // Element events of each channel
  assign rx_acc = run && per_rx_valid_i && rxr_r;
  assign tx_load = run && dir_r == ddc_pkg::DIR_M2P && f_valid && dyl_r != '0
                   && (!txv_r || per_tx_ready_i);
  assign src_step = go_src || rx_acc;
  assign dst_step = go_dst || tx_load;
  assign seq_end = run && syl_r == '0 && dyl_r == '0 && !req_r && !txv_r;
  assign fin_desc = ack_ok && tag_r == ddc_pkg::TAG_DESC
                    && widx_r == desc_words(flow_r) - 3'h1;
  assign fin_ok = fin_desc && !(flow_r == ddc_pkg::FL_ARRAY && dword == '0);

  // FIFO feed from memory reads or the peripheral
  assign f_push = (ack_ok && tag_r == ddc_pkg::TAG_SRC) || rx_acc;
  assign f_in = rx_acc ? per_rx_data_i : mem_rdata_i;

  ddc_fifo #(
    .W(`DDC_DW),
    .D(`DDC_FIFO_DEPTH),
    .AW(`DDC_FIFO_AW)
  ) u_fifo (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .flush_i(st_r == ddc_pkg::ST_IDLE),
    .in_valid_i(f_push),
    .in_ready_o(in_ready),
    .in_data_i(f_in),
    .out_valid_o(f_valid),
    .out_ready_i(go_dst || tx_load),
    .out_data_o(f_out),
    .count_o(f_cnt)
  );

  // ********************
  // Memory master
  // ********************
  // One request outstanding; held until ack
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= '0;
      wd_r <= '0;
      tag_r <= ddc_pkg::TAG_DESC;
    end else if (req_r) begin
      if (mem_ack_i) req_r <= 1'b0;
    end else if (go_desc) begin
      req_r <= 1'b1;
      we_r <= 1'b0;
      addr_r <= dptr_r + {27'h0, widx_r, 2'h0};
      tag_r <= ddc_pkg::TAG_DESC;
    end else if (go_dst) begin
      req_r <= 1'b1;
      we_r <= 1'b1;
      addr_r <= da_r;
      wd_r <= f_out;
      tag_r <= ddc_pkg::TAG_DST;
    end else if (go_src) begin
      req_r <= 1'b1;
      we_r <= 1'b0;
      addr_r <= sa_r;
      tag_r <= ddc_pkg::TAG_SRC;
    end
  end

  // ********************
  // Peripheral side
  // ********************
  // Ready is registered, so keep two words of headroom
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rxr_r <= 1'b0;
    end else begin
      rxr_r <= run && dir_r == ddc_pkg::DIR_P2M && syl_r != '0
               && !(rx_acc && syl_r == `DDC_CW'h1 && sxl_r == `DDC_CW'h1)
               && f_cnt < (`DDC_FIFO_AW+1)'(`DDC_FIFO_DEPTH - 2);
    end
  end

  // Output holding register toward the peripheral
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txv_r <= 1'b0;
      txd_r <= '0;
    end else if (tx_load) begin
      txv_r <= 1'b1;
      txd_r <= f_out;
    end else if (per_tx_ready_i || st_r == ddc_pkg::ST_IDLE) begin
      txv_r <= 1'b0;
    end
  end

  // ********************
  // Channel control
  // ********************
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= ddc_pkg::ST_IDLE;
      flow_r <= ddc_pkg::FL_STOP;
      dir_r <= ddc_pkg::DIR_M2M;
      frac_r <= 2'h0;
      {dptr_r, next_r, sa_r, da_r, sa0_r, da0_r} <= '0;
      {sxm_r, sym_r, dxm_r, dym_r} <= '0;
      {xc_r, yc_r, sxl_r, syl_r, dxl_r, dyl_r} <= '0;
      widx_r <= 3'h0;
    end else if (ack_err) begin
      st_r <= ddc_pkg::ST_IDLE;
    end else if (st_r == ddc_pkg::ST_IDLE) begin
      if (start_i) begin
        flow_r <= flow_i;
        dir_r <= dir_i;
        frac_r <= frac_i;
        dptr_r <= desc_ptr_i;
        {sa_r, sa0_r, da_r, da0_r} <= {src_addr_i, src_addr_i, dst_addr_i, dst_addr_i};
        {sxm_r, sym_r, dxm_r, dym_r} <= {src_xmod_i, src_ymod_i, dst_xmod_i, dst_ymod_i};
        {xc_r, yc_r, sxl_r, dxl_r} <= {xcnt_i, ycnt_i, xcnt_i, xcnt_i};
        {syl_r, dyl_r} <= {ycnt_i, ycnt_i};
        widx_r <= 3'h0;
        if (flow_i == ddc_pkg::FL_STOP || flow_i == ddc_pkg::FL_AUTO) begin
          st_r <= ddc_pkg::ST_RUN;
        end else begin
          st_r <= ddc_pkg::ST_FETCH;
        end
      end
    end else if (st_r == ddc_pkg::ST_FETCH) begin
      if (ack_ok) begin
        widx_r <= widx_r + 3'h1;
        unique case ({flow_r, widx_r})
          {ddc_pkg::FL_ARRAY, 3'h0}: sa_r <= dword;
          {ddc_pkg::FL_PING, 3'h0}, {ddc_pkg::FL_LIST, 3'h0},
          {ddc_pkg::FL_LIST2D, 3'h0}: next_r <= dword;
          {ddc_pkg::FL_PING, 3'h1}, {ddc_pkg::FL_LIST, 3'h1},
          {ddc_pkg::FL_LIST2D, 3'h1}: sa_r <= dword;
          {ddc_pkg::FL_LIST, 3'h2}: {xc_r, yc_r, sym_r} <= {dword[`DDC_CW-1:0], `DDC_CW'h1, sxm_r};
          {ddc_pkg::FL_LIST2D, 3'h2}: xc_r <= dword[`DDC_CW-1:0];
          {ddc_pkg::FL_LIST2D, 3'h3}: sxm_r <= dword;
          {ddc_pkg::FL_LIST2D, 3'h4}: yc_r <= dword[`DDC_CW-1:0];
          {ddc_pkg::FL_LIST2D, 3'h5}: sym_r <= dword;
          {ddc_pkg::FL_LIST, 3'h3}, {ddc_pkg::FL_LIST2D, 3'h6}:
            flow_r <= ddc_pkg::ddc_flow_type'(dword[`DDC_CFG_FLOW_MSB:`DDC_CFG_FLOW_LSB]);
          default: ;
        endcase
        if (fin_desc && !fin_ok) begin
          st_r <= ddc_pkg::ST_IDLE;
        end else if (fin_ok) begin
          st_r <= ddc_pkg::ST_RUN;
          {sxl_r, dxl_r, syl_r, dyl_r} <= {xc_r, xc_r, yc_r, yc_r};
        end
      end
    end else begin
      if (src_step) begin
        sa_r <= step_addr(sa_r, sxl_r, sxm_r, sym_r);
        {sxl_r, syl_r} <= step_cnt(sxl_r, syl_r, xc_r);
      end
      if (dst_step && dir_r != ddc_pkg::DIR_M2P) begin
        da_r <= step_addr(da_r, dxl_r, dxm_r, dym_r);
      end
      if (dst_step) begin
        {dxl_r, dyl_r} <= step_cnt(dxl_r, dyl_r, xc_r);
      end
      if (seq_end) begin
        widx_r <= 3'h0;
        unique case (flow_r)
          ddc_pkg::FL_STOP: st_r <= ddc_pkg::ST_IDLE;
          ddc_pkg::FL_AUTO: begin
            {sa_r, da_r} <= {sa0_r, da0_r};
            {sxl_r, dxl_r, syl_r, dyl_r} <= {xc_r, xc_r, yc_r, yc_r};
          end
          ddc_pkg::FL_ARRAY: begin
            dptr_r <= dptr_r + `DDC_WORD_BYTES;
            st_r <= ddc_pkg::ST_FETCH;
          end
          default: begin
            dptr_r <= next_r;
            st_r <= ddc_pkg::ST_FETCH;
          end
        endcase
      end
    end
  end

  // ********************
  // Buffer interrupts
  // ********************
  // Whole, half, quarter or eighth of the buffer; tiny buffers interrupt per element
  assign frac_len = ({16'h0, xc_r} * {16'h0, yc_r}) >> frac_r;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fcnt_r <= '0;
      irq_r <= 1'b0;
    end else if (!run) begin
      fcnt_r <= '0;
      irq_r <= 1'b0;
    end else if (dst_step && fcnt_r + 32'h1 >= frac_len) begin
      fcnt_r <= '0;
      irq_r <= 1'b1;
    end else begin
      fcnt_r <= fcnt_r + {31'h0, dst_step};
      irq_r <= 1'b0;
    end
  end

  // ********************
  // Status
  // ********************
  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if ((seq_end && flow_r == ddc_pkg::FL_STOP) || (fin_desc && !fin_ok)) begin
        done_r <= 1'b1;
      end else if (clear_i) begin
        done_r <= 1'b0;
      end
      if (ack_err) begin
        err_r <= 1'b1;
      end else if (clear_i) begin
        err_r <= 1'b0;
      end
    end
  end

  // ********************
  // Outputs
  // ********************
  assign mem_req_o = req_r;
  assign mem_we_o = we_r;
  assign mem_addr_o = addr_r;
  assign mem_wdata_o = wd_r;
  assign per_rx_ready_o = rxr_r;
  assign per_tx_valid_o = txv_r;
  assign per_tx_data_o = txd_r;
  assign busy_o = (st_r != ddc_pkg::ST_IDLE) || req_r; // Busy from state flops
  assign done_o = done_r;
  assign err_o = err_r;
  assign irq_o = irq_r;
endmodule : ddc_dma

// File: ddc_mem_model.sv
// Purpose: Memory slave model facing the stream's memory port.
// Assumes: 256 words seen through address bits 9:2.
// Notes: Bench sets the answer latency and one faulting address.
module ddc_mem_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [7:0] lat_i,
  input wire logic [31:0] err_addr_i,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [256];
  logic [7:0] wait_r;
  // ********
  // Answer
  // ********
  // Wait lat_i cycles, then answer once; any address is served
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      wait_r <= 8'h00;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= ~rdata_o; // No stale word once released
    end else if (req_i && wait_r >= lat_i) begin
      ack_o <= 1'b1;
      err_o <= (addr_i == err_addr_i);
      wait_r <= 8'h00;
      if (we_i) mem[addr_i[9:2]] <= wdata_i;
      else rdata_o <= mem[addr_i[9:2]];
    end else if (req_i) begin
      wait_r <= wait_r + 8'h01;
    end
  end
endmodule : ddc_mem_model

// File: ddc_dma_chk.sv
// Purpose: Port assertions for the DMA stream.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to ddc_dma below.
`include "ddc_defines.svh"
module ddc_dma_chk (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic clear_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [`DDC_AW-1:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic per_tx_valid_o,
  input wire logic [`DDC_DW-1:0] per_tx_data_o,
  input wire logic per_tx_ready_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic err_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // ********
  // Memory beat steps
  // ********
  sequence wait_s;
    mem_req_o && !mem_ack_i;
  endsequence
  sequence beat_s;
    mem_req_o && mem_ack_i;
  endsequence
  req_hold_a: assert property (
    wait_s |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("request moved before its answer");
  req_gap_a: assert property (beat_s |=> !mem_req_o)
    else $error("no idle cycle after answer");
  // Idle without a start must stay off the memory port
  idle_quiet_a: assert property (!busy_o && !start_i |=> !mem_req_o)
    else $error("request while idle");
  start_busy_a: assert property (start_i && !busy_o |=> busy_o)
    else $error("start not taken");
  err_abort_a: assert property (
    beat_s ##0 mem_err_i |-> ##[1:4] (err_o && !busy_o))
    else $error("bus error not reported");
  flag_keep_a: assert property (done_o && !clear_i |=> done_o)
    else $error("done flag lost");
  err_keep_a: assert property (err_o && !clear_i |=> err_o)
    else $error("error flag lost");
  flag_clear_a: assert property (
    clear_i && !busy_o |=> !done_o && !err_o)
    else $error("flags not cleared");
  irq_pulse_a: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than a cycle");
  tx_hold_a: assert property (
    per_tx_valid_o && !per_tx_ready_i |=> per_tx_valid_o && $stable(per_tx_data_o))
    else $error("tx word dropped before taken");
endmodule : ddc_dma_chk
bind ddc_dma ddc_dma_chk i_chk (.clock_i, .rstn_i, .start_i, .clear_i, .mem_req_o,
  .mem_we_o, .mem_addr_o, .mem_ack_i, .mem_err_i, .per_tx_valid_o, .per_tx_data_o,
  .per_tx_ready_i, .busy_o, .done_o, .err_o, .irq_o);

// File: test_descriptor_dma_controller.sv
// Purpose: Self-checking bench for the DMA stream.
// Assumes: Memory word i preset to A000_0000 or 4i.
// Notes: Free-running flows are stopped by a reset.
module test_descriptor_dma_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rstn_i, start_i, clear_i, mem_req_o, mem_we_o, mem_ack_i, mem_err_i;
  logic per_rx_valid_i, per_rx_ready_o, per_tx_valid_o, per_tx_ready_i;
  logic busy_o, done_o, err_o, irq_o, low;
  logic [1:0] frac_i;
  logic [7:0] lat;
  logic [15:0] xcnt_i, ycnt_i;
  logic [31:0] desc_ptr_i, src_addr_i, dst_addr_i, src_xmod_i, src_ymod_i, dst_xmod_i;
  logic [31:0] dst_ymod_i, mem_addr_o, mem_wdata_o, mem_rdata_i, per_rx_data_i;
  logic [31:0] per_tx_data_o, err_addr, a;
  ddc_pkg::ddc_flow_type flow_i;
  ddc_pkg::ddc_dir_type dir_i;
  int n_errors = 0, checks_done = 0, cycles = 0, n_irq = 0, k;
  typedef struct {logic [1:0] fr; logic [31:0] sa; logic [15:0] x, y;
    logic [31:0] xm, ym; int nirq;} ddc_row_type;
  // Stop-mode rows: frac, source, counts, strides, interrupts
  ddc_row_type rows [4] = '{
    '{2'h0, 32'h0000_0000, 16'h0004, 16'h0001, 32'h0000_0004, 32'h0000_0004, 1},
    '{2'h1, 32'h0000_0040, 16'h0004, 16'h0001, 32'hFFFF_FFFC, 32'hFFFF_FFFC, 2},
    '{2'h0, 32'h0000_0010, 16'h0003, 16'h0001, 32'h0000_0000, 32'h0000_0000, 1},
    '{2'h2, 32'h0000_0020, 16'h0002, 16'h0003, 32'h0000_0004, 32'h0000_0008, 6}};
  ddc_dma i_dut (.*);
  ddc_mem_model i_mem (.clock_i, .rstn_i, .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .lat_i(lat), .err_addr_i(err_addr),
    .ack_o(mem_ack_i), .err_o(mem_err_i), .rdata_o(mem_rdata_i));
  // ********
  // Clock, hang guard, interrupt count
  // ********
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (irq_o === 1'b1) n_irq++;
    if (cycles == 30000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ********
  // Tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic do_reset();
    rstn_i = 1'b0;
    repeat (20) @(negedge clock_i);
    rstn_i = 1'b1;
  endtask : do_reset
  task automatic fill();
    for (int i = 0; i < 256; i++) i_mem.mem[i] = 32'hA000_0000 | (i << 2);
  endtask : fill
  task automatic put(input int base, input logic [31:0] w[$]);
    foreach (w[i]) i_mem.mem[base + i] = w[i];
  endtask : put
  task automatic go(input logic [2:0] fl, input logic [1:0] dr, input logic [1:0] fr,
      input logic [31:0] dp, input logic [31:0] sa, input logic [15:0] x,
      input logic [15:0] y, input logic [31:0] xm, input logic [31:0] ym);
    @(negedge clock_i);
    flow_i = ddc_pkg::ddc_flow_type'(fl);
    dir_i = ddc_pkg::ddc_dir_type'(dr);
    {frac_i, desc_ptr_i, src_addr_i, xcnt_i, ycnt_i, src_xmod_i, src_ymod_i} =
      {fr, dp, sa, x, y, xm, ym};
    n_irq = 0;
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
  endtask : go
  task automatic wait_idle();
    for (k = 0; k < 3000 && busy_o !== 1'b0; k++) @(negedge clock_i);
    check("idle", k < 3000, 1);
  endtask : wait_idle
  task automatic expect_dst(input logic [31:0] s[$]);
    foreach (s[i]) check("dst word", i_mem.mem[8'h80 + i], 32'hA000_0000 | s[i]);
  endtask : expect_dst
  task automatic pulse_clear();
    clear_i = 1'b1;
    @(negedge clock_i);
    clear_i = 1'b0;
    @(negedge clock_i);
  endtask : pulse_clear
  task automatic free_run(input logic [2:0] fl, input logic [31:0] w2);
    fill();
    put(8'hF0, '{32'h0000_03C8, 32'h0000_0060, 32'h0000_03C0, 32'h0000_0070});
    go(fl, 2'h0, 2'h0, 32'h0000_03C0, 32'h0000_0050, 16'h0002, 16'h0001, 32'h4, 32'h4);
    for (k = 0; k < 500 && n_irq < 3; k++) @(negedge clock_i);
    check("running", {busy_o, done_o}, 2'b10);
    check("third word", i_mem.mem[8'h82], w2);
    do_reset();
    check("mid reset outs", {busy_o, mem_req_o, done_o, irq_o, per_tx_valid_o}, 0);
  endtask : free_run
  // ********
  // Main sequence
  // ********
  initial begin
    {rstn_i, start_i, clear_i, per_rx_valid_i, per_tx_ready_i, lat} = '0;
    {per_rx_data_i, dst_addr_i, dst_xmod_i, dst_ymod_i} = {32'h0, 32'h200, 32'h4, 32'h4};
    err_addr = 32'hFFFF_FFFC;
    go(3'h0, 2'h0, 2'h0, 32'h0, 32'h0, 16'h1, 16'h1, 32'h4, 32'h4);
    repeat (18) @(negedge clock_i);
    check("reset outs", {busy_o, mem_req_o, done_o, err_o, irq_o, per_tx_valid_o}, 0);
    rstn_i = 1'b1;
    foreach (rows[r]) begin
      pulse_clear();
      fill();
      go(3'h0, 2'h0, rows[r].fr, 32'h0, rows[r].sa, rows[r].x, rows[r].y, rows[r].xm,
        rows[r].ym);
      wait_idle();
      check("irqs", n_irq, rows[r].nirq);
      check("done", done_o, 1);
      a = rows[r].sa;
      for (int j = 0; j < rows[r].x * rows[r].y; j++) begin
        check("copy", i_mem.mem[8'h80 + j], 32'hA000_0000 | a);
        a += ((j + 1) % rows[r].x == 0) ? rows[r].ym : rows[r].xm;
      end
    end
    // Descriptor list and array chains, then a single 2D list descriptor
    fill();
    put(8'hC0, '{32'h310, 32'h0, 32'h2, 32'h6, 32'h0, 32'h20, 32'h2, 32'h0});
    go(3'h6, 2'h0, 2'h0, 32'h300, 32'h0, 16'h1, 16'h1, 32'h4, 32'h4);
    wait_idle();
    expect_dst('{32'h0, 32'h4, 32'h20, 32'h24});
    fill();
    put(8'hD0, '{32'h10, 32'h30, 32'h0});
    go(3'h4, 2'h0, 2'h0, 32'h340, 32'h0, 16'h2, 16'h1, 32'h4, 32'h4);
    wait_idle();
    expect_dst('{32'h10, 32'h14, 32'h30, 32'h34});
    fill();
    put(8'hE0, '{32'h0, 32'h40, 32'h2, 32'hFFFF_FFFC, 32'h2, 32'h10, 32'h0});
    go(3'h7, 2'h0, 2'h0, 32'h380, 32'h0, 16'h1, 16'h1, 32'h4, 32'h4);
    wait_idle();
    expect_dst('{32'h40, 32'h3C, 32'h4C, 32'h48});
    // Memory to peripheral with the sink stalling every other cycle
    go(3'h0, 2'h1, 2'h0, 32'h0, 32'h0, 16'h4, 16'h1, 32'h4, 32'h4);
    for (int c = 0, n = 0; c < 300 && n < 4; c++) begin
      per_tx_ready_i = c[0];
      @(posedge clock_i);
      if (per_tx_valid_o === 1'b1 && per_tx_ready_i) begin
        check("tx word", per_tx_data_o, 32'hA000_0000 | (n << 2));
        n++;
      end
      @(negedge clock_i);
    end
    wait_idle();
    // Peripheral to slow memory: buffer fills until refused, then drains
    lat = 8'h0C;
    low = 1'b0;
    per_rx_valid_i = 1'b1;
    go(3'h0, 2'h2, 2'h0, 32'h0, 32'h0, 16'h14, 16'h1, 32'h4, 32'h4);
    for (int c = 0, n = 0; c < 3000 && n < 20; c++) begin
      per_rx_data_i = 32'h5000_0000 + n;
      @(posedge clock_i);
      if (per_rx_ready_o === 1'b1) n++;
      else if (n > 0) low = 1'b1;
      @(negedge clock_i);
    end
    per_rx_valid_i = 1'b0;
    check("refused", low, 1);
    wait_idle();
    for (int i = 0; i < 20; i++) check("rx word", i_mem.mem[8'h80 + i], 32'h5000_0000 + i);
    // Bus error mid-transfer
    lat = 8'h00;
    err_addr = 32'h0000_0008;
    pulse_clear();
    check("cleared", done_o, 0);
    go(3'h0, 2'h0, 2'h0, 32'h0, 32'h0, 16'h4, 16'h1, 32'h4, 32'h4);
    wait_idle();
    check("error", {err_o, done_o}, 2'b10);
    pulse_clear();
    check("err cleared", err_o, 0);
    err_addr = 32'hFFFF_FFFC;
    free_run(3'h1, 32'hA000_0208);
    free_run(3'h5, 32'hA000_0070);
    give_verdict();
  end
endmodule : test_descriptor_dma_controller
